// >>> tb/acs_checker.sv
// concurrent checks on the conversion sequencer top ports
// assumes binding to acs_sequencer; one clock domain, async active-low reset
module acs_checker (
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic [2:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic [15:0] port_read_value,
    input wire logic        conv_sampling,
    input wire logic        conv_active,
    input wire logic [3:0]  channel_select,
    input wire logic        timer_reset,
    input wire logic        converter_irq_flag
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    // at least eight cycles active, and low again at most 720 cycles after those eight, above the 704 of eleven 64-cycle periods
    a_conv_span: assert property ($rose(conv_active) |-> conv_active [*8] ##[1:720] !conv_active)
        else $error("conversion length out of range");
    a_phase_excl: assert property (!(conv_active && conv_sampling))
        else $error("sampling while converting");
    a_wait_after: assert property ($fell(conv_active) |-> !conv_sampling [*2])
        else $error("sampling resumed without the wait");
    a_pins_zero: assert property (port_read_value[6:5] == 2'h0 && port_read_value[9:8] == 2'h0)
        else $error("unimplemented pin bits read nonzero");
    a_irq_cause: assert property ($rose(converter_irq_flag) |-> $past(conv_active) || $past(reg_wr))
        else $error("flag set without completion or write");
    a_chan_write: assert property ($changed(channel_select) |-> $past(reg_wr) && $past(reg_addr) == 3'h2)
        else $error("channel changed without a control write");
    a_trig_pulse: assert property (timer_reset |=> !timer_reset)
        else $error("timer reset longer than one cycle");
endmodule

bind acs_sequencer acs_checker acs_checker_i (.core_clk, .resetn, .reg_addr, .reg_wr, .reg_rd, .reg_rdata,
    .port_read_value, .conv_sampling, .conv_active, .channel_select, .timer_reset, .converter_irq_flag);

// >>> tb/acs_front_end.sv
// behavioural analog front end: code source for the sample-and-hold and comparator
// assumes the bench sets the channel code and the converter offset code
module acs_front_end (
    input  wire logic       core_clk,
    input  wire logic       conv_active,
    input  wire logic       conv_dummy,
    input  wire logic [9:0] code,
    input  wire logic [9:0] cal_code,
    output logic      [9:0] conv_raw
);
    timeunit 1ns;
    timeprecision 1ns;
    logic churn_reg = 1'b0;
    // no code is held outside a conversion, so the lines churn rather than keep the last value
    always @(posedge core_clk)
        churn_reg <= ~churn_reg;
    // a dummy run sees no channel, only the converter's own offset
    // the selected pin is taken as an input, so code is its analog level and not a driven one
    assign conv_raw = !conv_active ? ({10{churn_reg}} ^ code) : (conv_dummy ? cal_code : code);
endmodule

// >>> tb/test_adc_conversion_sequencer.sv
// self-checking bench for the conversion sequencer with a bench model of results
// assumes acs_front_end as the analog side and acs_checker bound to the top
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; \
$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module test_adc_conversion_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, special_trigger = 1'b0;
    logic [2:0]  reg_addr = 3'h0;
    logic [7:0]  reg_wdata = 8'h00, port_pins_low = 8'h00, port_pins_high = 8'h00, reg_rdata, rd_val, eh, el;
    logic [9:0]  code = 10'h000, cal_code = 10'h000, conv_raw;
    logic [15:0] port_read_value;
    logic [3:0]  channel_select;
    logic        conv_sampling, conv_active, conv_dummy, timer_reset, converter_irq_flag;
    int          n_mismatch = 0, total_checks = 0, seed = 39, alen = 0, trigs = 0, offs = 0, cs = 0, fmt = 0;
    int          per[8] = '{2, 8, 32, 40, 4, 16, 64, 40};
    int          acq_tad[8] = '{0, 2, 4, 6, 8, 12, 15, 15};
    int          qlen = 0;
    initial forever #50 core_clk = ~core_clk;
    acs_sequencer acs_sequencer_i (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .special_trigger, .port_pins_low, .port_pins_high, .port_read_value, .conv_raw, .conv_sampling,
        .conv_active, .conv_dummy, .channel_select, .timer_reset, .converter_irq_flag);
    acs_front_end acs_front_end_i (.core_clk, .conv_active, .conv_dummy, .code, .cal_code, .conv_raw);
    always @(posedge core_clk) begin
        if (conv_active)
            alen++;
        if (conv_sampling && !conv_active && alen == 0)
            qlen++;
        if (timer_reset)
            trigs++;
    end
    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // an idle cycle after each strobe keeps one assignment per signal per time step
    task wr(input logic [2:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task rc(input logic [2:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        // the answer stands only until the next edge, so it is taken mid-cycle
        @(negedge core_clk);
        rd_val = reg_rdata;
        @(posedge core_clk);
        `CHK(rd_val, e)
    endtask
    // k: 0 flag set, 1 converting, 2 sampling again
    task wt(input int k);
        for (int j = 0; j < 3000; j++) begin
            if ((k == 0 && converter_irq_flag === 1'b1) || (k == 1 && conv_active === 1'b1) ||
                (k == 2 && conv_sampling === 1'b1))
                return;
            @(posedge core_clk);
        end
        n_mismatch++;
        end_of_test;
    endtask
    task conv(input int acq, input bit cal);
        int e;
        code = 10'($random(seed));
        wr(3'h3, {fmt[0], cal, acq[2:0], cs[2:0]});
        alen <= 0;
        qlen <= 0;
        wr(3'h2, {2'h0, code[3:0], 2'h3});
        rc(3'h2, {2'h0, code[3:0], 2'h3});
        wt(0);
        `CHK(alen >= 10 * per[cs] + 1 && alen <= 11 * per[cs] + 1, 1'b1)
        // start edge plus four core cycles, or plus the programmed ticks at a free-running phase
        `CHK(acq == 0 ? qlen == 1 + 4 : qlen >= (acq_tad[acq] - 1) * per[cs] + 2 && qlen <= acq_tad[acq] * per[cs] + 1, 1'b1)
        e = cal ? cal_code - offs : (code > offs ? code - offs : 0);
        eh = fmt ? {6'h00, e[9:8]} : e[9:2];
        el = fmt ? e[7:0] : {e[1:0], 6'h00};
        rc(3'h0, eh);
        rc(3'h1, el);
        if (!cal)
            rc(3'h6, 8'h01);
        if (cal)
            offs = cal_code;
        wr(3'h6, 8'h00);
        wt(2);
    endtask
    initial begin
        #10000000;
        n_mismatch++;
        end_of_test;
    end
    initial begin
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        rc(3'h2, 8'h00);
        rc(3'h3, 8'h00);
        rc(3'h7, 8'h00);
        wr(3'h2, 8'h03);
        rc(3'h2, 8'h01);
        cal_code = 10'($random(seed)) & 10'h03F;
        fmt = 1;
        conv(0, 1'b1);
        for (int k = 0; k < 16; k++) begin
            cs = k % 8;
            fmt = k / 8;
            conv(k < 8 ? 0 : (k == 8 ? 2 : k - 8), 1'b0);
        end
        // abort twelve cycles into the conversion, still within its first 64-cycle period
        wr(3'h3, {fmt[0], 7'h06});
        wr(3'h2, 8'h03);
        wt(1);
        repeat (12) @(posedge core_clk);
        wr(3'h2, 8'h01);
        wt(2);
        rc(3'h0, eh);
        rc(3'h1, el);
        rc(3'h6, 8'h00);
        wr(3'h5, 8'h0B);
        trigs = 0;
        special_trigger <= 1'b1;
        wt(1);
        special_trigger <= 1'b0;
        wt(0);
        wr(3'h6, 8'h00);
        wt(2);
        wr(3'h2, 8'h00);
        special_trigger <= 1'b1;
        repeat (8) @(posedge core_clk);
        special_trigger <= 1'b0;
        repeat (8) @(posedge core_clk);
        `CHK(trigs, 2)
        rc(3'h6, 8'h00);
        wr(3'h4, 8'h10);
        wr(3'h2, 8'hFF);
        wr(3'h3, 8'hFF);
        port_pins_low <= 8'($random(seed));
        port_pins_high <= 8'($random(seed));
        rc(3'h2, 8'h9F);
        rc(3'h3, 8'hFC);
        repeat (2) @(posedge core_clk);
        `CHK(port_read_value, {port_pins_high & 8'hFC, port_pins_low & 8'h9F})
        wr(3'h4, 8'h00);
        rc(3'h2, 8'h00);
        end_of_test;
    end
endmodule

// >>> verilog/acs_clkdiv.v
// conversion clock tick generator: one core_clk pulse per conversion clock period
// assumes core_clk is the oscillator and the rc tick comes from a free counter here
`include "acs_map.vh"
module acs_clkdiv (
    input  wire       core_clk,
    input  wire       resetn,
    input  wire [2:0] sel,
    input  wire       run,
    output reg        tick
);
    reg  [6:0] cnt_reg;
    reg  [6:0] limit;
    always @* begin
        // binary code order: 000=2,100=4,001=8,101=16,010=32,110=64 oscillator periods
        case (sel)
            3'h0:    limit = 7'h01;
            3'h4:    limit = 7'h03;
            3'h1:    limit = 7'h07;
            3'h5:    limit = 7'h0F;
            3'h2:    limit = 7'h1F;
            3'h6:    limit = 7'h3F;
            // rc stand-in counts core_clk, so it cannot model the slower clock that sleep would allow
            default: limit = {1'b0, `ACS_RC_HALF} + {1'b0, `ACS_RC_HALF} - 7'h01;
        endcase
    end
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= 7'h00;
            tick    <= 1'b0;
        end else if (!run) begin
            cnt_reg <= 7'h00;
            tick    <= 1'b0;
        end else if (cnt_reg >= limit) begin
            cnt_reg <= 7'h00;
            tick    <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 7'h01;
            tick    <= 1'b0;
        end
    end
endmodule

// >>> verilog/acs_map.vh
// register offsets, field positions, reset values and timing counts of the conversion sequencer
// assumes inclusion by bare name from the design files
`ifndef ACS_MAP_VH
`define ACS_MAP_VH
`define ACS_ADDR_W         3
`define ACS_OFF_RESH       3'h0
`define ACS_OFF_RESL       3'h1
`define ACS_OFF_CTL0       3'h2
`define ACS_OFF_CTL1       3'h3
`define ACS_OFF_WDT        3'h4
`define ACS_OFF_CCP        3'h5
`define ACS_OFF_STAT       3'h6
`define ACS_CTL0_EN        0
`define ACS_CTL0_GO        1
`define ACS_CTL1_CAL       6
`define ACS_CTL1_FMT       7
`define ACS_WDT_SHR        4
`define ACS_CTL0_RST       8'h00
`define ACS_CTL1_RST       8'h00
`define ACS_ANALOG_PIN_CONFIG_LOW_RST     8'h00
`define ACS_ANALOG_PIN_CONFIG_HIGH_RST     8'h00
`define ACS_ANALOG_PIN_CONFIG_LOW_MASK    8'h9F
`define ACS_ANALOG_PIN_CONFIG_HIGH_MASK    8'hFC
`define ACS_CCP_TRIG_MODE  4'hB
`define ACS_CONV_TAD       4'hB
`define ACS_ACQ4_TAD       4'h4
`define ACS_WAIT_TAD       4'h2
`define ACS_INSTR_CYC      3'h4
`define ACS_RC_HALF        6'h14
`endif

// >>> verilog/acs_sequencer.v
// conversion sequencer top: register file, acquisition/convert/wait state machine, calibration
// assumes a single-cycle register port master on core_clk and an analog front end that
// presents a 10-bit raw code on conv_raw whenever conv_active ends
`include "acs_map.vh"
module acs_sequencer (
    input  wire        core_clk,
    input  wire        resetn,
    input  wire [2:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    input  wire        special_trigger,
    input  wire [7:0]  port_pins_low,
    input  wire [7:0]  port_pins_high,
    output wire [15:0] port_read_value,
    input  wire [9:0]  conv_raw,
    output wire        conv_sampling,
    output wire        conv_active,
    output wire        conv_dummy,
    output wire [3:0]  channel_select,
    output wire        timer_reset,
    output reg         converter_irq_flag
);
    localparam ST_IDLE = 3'h0;
    localparam ST_INST = 3'h1;
    localparam ST_ACQ  = 3'h2;
    localparam ST_CONV = 3'h3;
    localparam ST_WAIT = 3'h4;

    reg  [7:0] ctl0_reg;
    reg  [7:0] ctl1_reg;
    reg  [7:0] anc0_reg;
    reg  [7:0] anc1_reg;
    reg  [7:0] wdt_reg;
    reg  [7:0] ccp_reg;
    reg  [7:0] resh_reg;
    reg  [7:0] resl_reg;
    reg  [9:0] offset_reg;
    reg        cal_run_reg;
    reg  [2:0] state_reg;
    reg  [3:0] tad_cnt_reg;
    reg  [2:0] inst_cnt_reg;
    reg  [3:0] acq_len;
    reg  [15:0] pin_s1_reg;
    reg  [15:0] pin_s2_reg;
    reg        trig_s1_reg;
    reg        trig_s2_reg;
    reg        trig_d_reg;

    wire       tick;
    wire       shr        = wdt_reg[`ACS_WDT_SHR];
    wire       enabled    = ctl0_reg[`ACS_CTL0_EN];
    wire       go         = ctl0_reg[`ACS_CTL0_GO];
    wire [2:0] acq_sel    = ctl1_reg[5:3];
    wire       fmt        = ctl1_reg[`ACS_CTL1_FMT];
    wire       trig_edge  = trig_s2_reg & ~trig_d_reg;
    wire       trig_start = trig_edge & (ccp_reg[3:0] == `ACS_CCP_TRIG_MODE) & enabled;
    wire       wr_ctl0    = reg_wr & (reg_addr == `ACS_OFF_CTL0) & ~shr;
    wire       wr_ctl1    = reg_wr & (reg_addr == `ACS_OFF_CTL1) & ~shr;
    wire       sw_go_set  = wr_ctl0 & reg_wdata[`ACS_CTL0_GO] & ~go & enabled;
    wire       sw_abort   = wr_ctl0 & ~reg_wdata[`ACS_CTL0_GO] & go;
    wire       busy       = (state_reg == ST_INST) | (state_reg == ST_ACQ) | (state_reg == ST_CONV);
    // an abort or disable in the last tick wins, so a cut conversion never loads the result
    wire       done       = (state_reg == ST_CONV) & tick & enabled & ~sw_abort &
                            (tad_cnt_reg == `ACS_CONV_TAD - 4'h1);
    wire [9:0] corrected  = (conv_raw > offset_reg) ? (conv_raw - offset_reg) : 10'h000;
    wire [15:0] analog_mask = {anc1_reg & `ACS_ANALOG_PIN_CONFIG_HIGH_MASK, anc0_reg & `ACS_ANALOG_PIN_CONFIG_LOW_MASK};

    acs_clkdiv u_clkdiv (
        .core_clk (core_clk),
        .resetn   (resetn),
        .sel      (ctl1_reg[2:0]),
        .run      (enabled),
        .tick     (tick)
    );

    // pins and the trigger come from other domains; the second stage is read, plus a third trigger stage for the edge
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pin_s1_reg  <= 16'h0000;
            pin_s2_reg  <= 16'h0000;
            trig_s1_reg <= 1'b0;
            trig_s2_reg <= 1'b0;
            trig_d_reg  <= 1'b0;
        end else begin
            pin_s1_reg  <= {port_pins_high, port_pins_low};
            pin_s2_reg  <= pin_s1_reg;
            trig_s1_reg <= special_trigger;
            trig_s2_reg <= trig_s1_reg;
            trig_d_reg  <= trig_s2_reg;
        end
    end

    // a cleared config bit means analog, and an analog pin reads low whatever its level
    assign port_read_value = pin_s2_reg & analog_mask;
    assign timer_reset     = trig_edge & (ccp_reg[3:0] == `ACS_CCP_TRIG_MODE);
    assign channel_select  = ctl0_reg[5:2];
    // sampling runs whenever enabled and not converting or waiting; channel never gates it
    assign conv_sampling   = enabled & (state_reg != ST_CONV) & (state_reg != ST_WAIT);
    assign conv_active     = (state_reg == ST_CONV);
    assign conv_dummy      = (state_reg == ST_CONV) & cal_run_reg;

    always @* begin
        case (acq_sel)
            3'h1:    acq_len = 4'h2;
            3'h2:    acq_len = `ACS_ACQ4_TAD;
            3'h3:    acq_len = 4'h6;
            3'h4:    acq_len = 4'h8;
            3'h5:    acq_len = 4'hC;
            3'h6:    acq_len = 4'hF;
            3'h7:    acq_len = 4'hF;
            default: acq_len = 4'h0;
        endcase
    end

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg    <= ST_IDLE;
            tad_cnt_reg  <= 4'h0;
            inst_cnt_reg <= 3'h0;
            cal_run_reg  <= 1'b0;
            offset_reg   <= 10'h000;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    // a start set during the wait is held in the flag and taken once idle
                    if ((go & enabled) | sw_go_set | trig_start) begin
                        tad_cnt_reg  <= 4'h0;
                        inst_cnt_reg <= 3'h0;
                        cal_run_reg  <= ctl1_reg[`ACS_CTL1_CAL];
                        if (acq_sel == 3'h0)
                            state_reg <= ST_INST;
                        else
                            state_reg <= ST_ACQ;
                    end
                end
                ST_INST: begin
                    if (sw_abort | ~enabled) begin
                        state_reg <= ST_IDLE;
                    end else if (inst_cnt_reg == `ACS_INSTR_CYC - 3'h1) begin
                        state_reg <= ST_CONV;
                    end else begin
                        inst_cnt_reg <= inst_cnt_reg + 3'h1;
                    end
                end
                ST_ACQ: begin
                    if (sw_abort | ~enabled) begin
                        state_reg   <= ST_WAIT;
                        tad_cnt_reg <= 4'h0;
                    end else if (tick) begin
                        if (tad_cnt_reg == acq_len - 4'h1) begin
                            state_reg   <= ST_CONV;
                            tad_cnt_reg <= 4'h0;
                        end else begin
                            tad_cnt_reg <= tad_cnt_reg + 4'h1;
                        end
                    end
                end
                ST_CONV: begin
                    if (sw_abort | ~enabled) begin
                        state_reg   <= ST_WAIT;
                        tad_cnt_reg <= 4'h0;
                    end else if (tick) begin
                        if (done) begin
                            state_reg   <= ST_WAIT;
                            tad_cnt_reg <= 4'h0;
                            if (cal_run_reg)
                                offset_reg <= conv_raw;
                        end else begin
                            tad_cnt_reg <= tad_cnt_reg + 4'h1;
                        end
                    end
                end
                ST_WAIT: begin
                    if (~enabled) begin
                        state_reg <= ST_IDLE;
                    end else if (tick) begin
                        if (tad_cnt_reg == `ACS_WAIT_TAD - 4'h1)
                            state_reg <= ST_IDLE;
                        else
                            tad_cnt_reg <= tad_cnt_reg + 4'h1;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // register file; a hardware set of the irq flag wins over a software clear
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctl0_reg           <= `ACS_CTL0_RST;
            ctl1_reg           <= `ACS_CTL1_RST;
            anc0_reg           <= `ACS_ANALOG_PIN_CONFIG_LOW_RST;
            anc1_reg           <= `ACS_ANALOG_PIN_CONFIG_HIGH_RST;
            wdt_reg            <= 8'h00;
            ccp_reg            <= 8'h00;
            converter_irq_flag <= 1'b0;
        end else begin
            if (wr_ctl0)
                ctl0_reg <= {reg_wdata[7:2], reg_wdata[`ACS_CTL0_GO] & (enabled | go), reg_wdata[0]};
            if (wr_ctl1)
                ctl1_reg <= reg_wdata;
            if (reg_wr & (reg_addr == `ACS_OFF_CTL0) & shr)
                anc0_reg <= reg_wdata & `ACS_ANALOG_PIN_CONFIG_LOW_MASK;
            if (reg_wr & (reg_addr == `ACS_OFF_CTL1) & shr)
                anc1_reg <= reg_wdata & `ACS_ANALOG_PIN_CONFIG_HIGH_MASK;
            if (reg_wr & (reg_addr == `ACS_OFF_WDT))
                wdt_reg <= reg_wdata;
            if (reg_wr & (reg_addr == `ACS_OFF_CCP))
                ccp_reg <= reg_wdata;
            if (trig_start)
                ctl0_reg[`ACS_CTL0_GO] <= 1'b1;
            if (done | ~enabled & ~wr_ctl0)
                ctl0_reg[`ACS_CTL0_GO] <= 1'b0;
            if (reg_wr & (reg_addr == `ACS_OFF_STAT))
                converter_irq_flag <= reg_wdata[0];
            if (done)
                converter_irq_flag <= 1'b1;
        end
    end

    // result pair has no reset: it is untouched by any reset and by aborted conversions
    always @(posedge core_clk) begin
        if (done) begin
            if (fmt) begin
                resh_reg <= {6'h00, corrected[9:8]};
                resl_reg <= corrected[7:0];
            end else begin
                resh_reg <= corrected[9:2];
                resl_reg <= {corrected[1:0], 6'h00};
            end
        end else begin
            if (reg_wr & (reg_addr == `ACS_OFF_RESH))
                resh_reg <= reg_wdata;
            if (reg_wr & (reg_addr == `ACS_OFF_RESL))
                resl_reg <= reg_wdata;
        end
    end

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `ACS_OFF_RESH: reg_rdata <= resh_reg;
                `ACS_OFF_RESL: reg_rdata <= resl_reg;
                `ACS_OFF_CTL0: reg_rdata <= shr ? anc0_reg : {ctl0_reg[7:2], go | busy, ctl0_reg[0]};
                `ACS_OFF_CTL1: reg_rdata <= shr ? anc1_reg : ctl1_reg;
                `ACS_OFF_WDT:  reg_rdata <= wdt_reg;
                `ACS_OFF_CCP:  reg_rdata <= ccp_reg;
                `ACS_OFF_STAT: reg_rdata <= {5'h00, state_reg == ST_CONV, cal_run_reg, converter_irq_flag};
                default:       reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule
